// ===== hdl/ufr_map.svh
`ifndef UFR_MAP_SVH
`define UFR_MAP_SVH

// Command codes seen on the command port
`define UFR_CMD_OPERATION   8'h01
`define UFR_CMD_CLEAR_ALL   8'h03
`define UFR_CMD_UV_LIMIT    8'h44
`define UFR_CMD_UV_ACTION   8'h45
`define UFR_CMD_STATUS_VOUT 8'h7A
`define UFR_CMD_TIME_UNIT   8'hD2

// Field positions of the fault action byte
`define UFR_ACT_MODE_HI     7
`define UFR_ACT_MODE_LO     6
`define UFR_ACT_RETRY_HI    5
`define UFR_ACT_RETRY_LO    3
`define UFR_ACT_MULT_HI     2
`define UFR_ACT_MULT_LO     0

// Operation on bit and status fault bit
`define UFR_OP_ON_BIT       7
`define UFR_STAT_UV_BIT     4

// Retry field values with special meaning
`define UFR_RETRY_NONE      3'h0
`define UFR_RETRY_ENDLESS   3'h7

// Reset values
`define UFR_ACTION_RST      8'h80
`define UFR_LIMIT_RST       16'h0000
`define UFR_UNIT_RST        16'h0001
`define UFR_OP_RST          8'h80

// Timing: delay unit is counted in time-base ticks
`define UFR_CLK_NS          8
`define UFR_TBASE_NS        1000
`define UFR_TBASE_CYC       (`UFR_TBASE_NS / `UFR_CLK_NS)

`endif

// ===== hdl/ufr_pkg.sv
package ufr_pkg;

  // Reaction selected by the top two bits of the action byte
  typedef enum logic [1:0] {
    UFR_IGNORE   = 2'h0,
    UFR_DELAYED  = 2'h1,
    UFR_SHUTDOWN = 2'h2,
    UFR_HOLD     = 2'h3
  } ufr_mode_t;

  // Fault sequencer states, Gray coded along the retry path
  typedef enum logic [2:0] {
    UFR_S_RUN    = 3'h0,
    UFR_S_GRACE  = 3'h1,
    UFR_S_OFFW   = 3'h3,
    UFR_S_TRY    = 3'h2,
    UFR_S_LATCH  = 3'h6,
    UFR_S_HOLD   = 3'h7
  } ufr_state_t;

endpackage

// ===== hdl/ufr_sync.sv
`timescale 1ns/100ps
`default_nettype none

module ufr_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_clock,
  input  wire logic             i_sys_rst,
  input  wire logic [WIDTH-1:0] i_async,
  output var  logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  // Two flip-flops per bit; only the second stage is read
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      always_ff @(posedge i_clock)
      begin
        if (i_sys_rst)
        begin
          meta_r[g] <= 1'b0;
          sync_r[g] <= 1'b0;
        end
        else
        begin
          meta_r[g] <= i_async[g];
          sync_r[g] <= meta_r[g];
        end
      end
    end
  endgenerate

  assign o_sync = sync_r;

endmodule

`default_nettype wire

// ===== hdl/ufr_delay_timer.sv
`timescale 1ns/100ps
`default_nettype none

module ufr_delay_timer #(
  parameter int TBASE_CYC = 125
) (
  input  wire logic        i_clock,
  input  wire logic        i_sys_rst,
  input  wire logic        i_start,
  input  wire logic        i_stop,
  input  wire logic [2:0]  i_mult,
  input  wire logic [15:0] i_unit,
  output var  logic        o_done
);

  localparam int PW = $clog2(TBASE_CYC + 1);

  logic [PW-1:0] pre_r,  pre_nxt;
  logic [22:0]   cnt_r,  cnt_nxt;
  logic [22:0]   tgt_r,  tgt_nxt;
  logic          run_r,  run_nxt;
  logic          done_now;
  logic [15:0]   unit_eff;
  logic          tick;

  // Zero unit is taken as one unit
  assign unit_eff = (i_unit == 16'h0000) ? 16'h0001 : i_unit;
  assign tick     = (pre_r == PW'(TBASE_CYC - 1));
  // Done on the last tick itself, so starts are spaced by exactly the delay
  assign done_now = run_r && tick && ((cnt_r + 23'h000001) == tgt_r);

  // Delay is unit times two to the power of the multiplier field
  always_comb
  begin
    pre_nxt  = tick ? '0 : pre_r + PW'(1);
    cnt_nxt  = cnt_r;
    tgt_nxt  = tgt_r;
    run_nxt  = run_r;
    if (i_stop)
    begin
      run_nxt = 1'b0;
      pre_nxt = '0;
    end
    else if (i_start)
    begin
      run_nxt = 1'b1;
      pre_nxt = '0;
      cnt_nxt = '0;
      tgt_nxt = 23'(unit_eff) << i_mult; // RULE14
    end
    else if (run_r && tick)
    begin
      cnt_nxt = cnt_r + 23'h000001;
      if (done_now)
        run_nxt = 1'b0;
    end
  end

  // Timer state registers
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      pre_r  <= '0;
      cnt_r  <= '0;
      tgt_r  <= '0;
      run_r  <= 1'b0;
    end
    else
    begin
      pre_r  <= pre_nxt;
      cnt_r  <= cnt_nxt;
      tgt_r  <= tgt_nxt;
      run_r  <= run_nxt;
    end
  end

  assign o_done = done_now;

endmodule

`default_nettype wire

// ===== hdl/ufr_top.sv
// Summary of operation
// RULE1: Action byte bits 7:6 pick the reaction, 5:3 the retries, 2:0 the delay multiplier, at code 0x45.
// RULE2: Reaction 00 keeps the output running untouched by the fault.
// RULE3: Reaction 01 runs on for the delay and, if the fault remains, enters the retry sequence.
// RULE4: Reaction 10 turns the output off at once and enters the retry sequence.
// RULE5: Reaction 11 holds the output off only while the fault lasts, then resumes.
// RULE6: Retry value 000 makes no restart and keeps the output off until cleared.
// RULE7: Retry value 001 makes one restart and latches off if it fails.
// RULE8: Retry value 010 makes two restarts and latches off after the last failure.
// RULE9: Retry value 011 makes three restarts and latches off after the last failure.
// RULE10: Retry value 111 restarts without limit until commanded off or cleared.
// RULE11: Restart starts are spaced by the delay unit times two to the power of the multiplier.
// RULE12: A latched fault clears by status bit clear, clear-all command or the reset pin.
// RULE13: Commanding the output off then on, by pin or command, also clears the fault.
// RULE14: Multiplier 0 to 7 scales the delay to 1 through 128 units of the 0xD2 value.
// RULE15: Retry values 100, 101, 110 make four, five, six restarts, then latch off.
// RULE16: The fault is raised while the output is below the 16-bit limit at 0x44.
// RULE17: Any clearing event or successful restart resets the attempt count and timer.
`include "ufr_map.svh"
`timescale 1ns/100ps
`default_nettype none

module ufr_top #(
  parameter int TBASE_CYC = `UFR_TBASE_CYC
) (
  input  wire logic            I_CLOCK,
  input  wire logic            I_SYS_RST,
  input  wire logic [15:0]     I_VOUT,
  input  wire logic            I_CMD_WR,
  input  wire logic            I_CMD_RD,
  input  wire logic [7:0]      I_CMD_CODE,
  input  wire logic [15:0]     I_CMD_DATA,
  input  wire logic            I_CTRL_PIN,
  input  wire logic            I_RESET_PIN,
  output var  logic [15:0]     O_RD_DATA,
  output var  logic            O_RD_VALID,
  output var  logic            O_OUTPUT_EN,
  output var  logic            O_UV_FAULT,
  output var  logic            O_LATCHED,
  output var  logic [2:0]      O_ATTEMPTS,
  output var  ufr_pkg::ufr_state_t O_STATE
);

  import ufr_pkg::*;

  logic [1:0]  pins_s;
  logic        ctrl_s;
  logic        rstpin_s;
  logic        tmr_done;

  logic [7:0]  action_r,  action_nxt;
  logic [15:0] limit_r,   limit_nxt;
  logic [15:0] unit_r,    unit_nxt;
  logic [7:0]  op_r,      op_nxt;
  logic        stat_r,    stat_nxt;
  logic        cmd_on_r,  cmd_on_nxt;
  logic        rpin_d_r,  rpin_d_nxt;
  logic [15:0] rd_data_r, rd_data_nxt;
  logic        rd_vld_r,  rd_vld_nxt;

  ufr_state_t  state_r,   state_nxt;
  logic [2:0]  tries_r,   tries_nxt;
  logic        out_en_r,  out_en_nxt;
  logic        tmr_start;
  logic        tmr_stop;

  ufr_mode_t   mode;
  logic [2:0]  retries;
  logic [2:0]  mult;
  logic        uv_raw;
  logic        cmd_on;
  logic        on_edge;
  logic        clr_event;
  logic        wr_clear_all;
  logic        wr_stat_clr;

  // Pin inputs cross into the clock domain
  ufr_sync #(
    .WIDTH (2)
  ) u_sync (
    .i_clock   (I_CLOCK),
    .i_sys_rst (I_SYS_RST),
    .i_async   ({I_RESET_PIN, I_CTRL_PIN}),
    .o_sync    (pins_s)
  );

  assign ctrl_s   = pins_s[0];
  assign rstpin_s = pins_s[1];

  // Delay and restart spacing timer
  ufr_delay_timer #(
    .TBASE_CYC (TBASE_CYC)
  ) u_timer (
    .i_clock   (I_CLOCK),
    .i_sys_rst (I_SYS_RST),
    .i_start   (tmr_start),
    .i_stop    (tmr_stop),
    .i_mult    (mult),
    .i_unit    (unit_r),
    .o_done    (tmr_done)
  );

  // Action byte fields
  assign mode    = ufr_mode_t'(action_r[`UFR_ACT_MODE_HI:`UFR_ACT_MODE_LO]); // RULE1
  assign retries = action_r[`UFR_ACT_RETRY_HI:`UFR_ACT_RETRY_LO]; // RULE1
  assign mult    = action_r[`UFR_ACT_MULT_HI:`UFR_ACT_MULT_LO]; // RULE1

  // Fault condition and clearing events
  assign uv_raw  = (I_VOUT < limit_r); // RULE16
  assign cmd_on  = op_r[`UFR_OP_ON_BIT] & ctrl_s;
  assign on_edge = cmd_on & ~cmd_on_r; // RULE13
  assign wr_clear_all = I_CMD_WR && (I_CMD_CODE == `UFR_CMD_CLEAR_ALL);
  assign wr_stat_clr  = I_CMD_WR && (I_CMD_CODE == `UFR_CMD_STATUS_VOUT)
                        && I_CMD_DATA[`UFR_STAT_UV_BIT];
  assign clr_event = wr_clear_all | wr_stat_clr // RULE12
                     | (rstpin_s & ~rpin_d_r) | on_edge; // RULE12

  // Command writes, reads and the status bit
  always_comb
  begin
    action_nxt  = action_r;
    limit_nxt   = limit_r;
    unit_nxt    = unit_r;
    op_nxt      = op_r;
    cmd_on_nxt  = cmd_on;
    rpin_d_nxt  = rstpin_s;
    rd_vld_nxt  = I_CMD_RD;
    rd_data_nxt = rd_data_r;
    if (I_CMD_WR)
    begin
      case (I_CMD_CODE)
        `UFR_CMD_UV_ACTION: action_nxt = I_CMD_DATA[7:0];
        `UFR_CMD_UV_LIMIT:  limit_nxt  = I_CMD_DATA;
        `UFR_CMD_TIME_UNIT: unit_nxt   = I_CMD_DATA;
        `UFR_CMD_OPERATION: op_nxt     = I_CMD_DATA[7:0];
        default:            action_nxt = action_r;
      endcase
    end
    if (I_CMD_RD)
    begin
      case (I_CMD_CODE)
        `UFR_CMD_UV_ACTION:  rd_data_nxt = {8'h00, action_r};
        `UFR_CMD_UV_LIMIT:   rd_data_nxt = limit_r;
        `UFR_CMD_TIME_UNIT:  rd_data_nxt = unit_r;
        `UFR_CMD_OPERATION:  rd_data_nxt = {8'h00, op_r};
        `UFR_CMD_STATUS_VOUT:
          rd_data_nxt = 16'(stat_r) << `UFR_STAT_UV_BIT;
        default:             rd_data_nxt = 16'h0000;
      endcase
    end
    // A new fault wins over a clear in the same cycle
    stat_nxt = stat_r;
    if (clr_event)
      stat_nxt = 1'b0;
    if (uv_raw && out_en_r)
      stat_nxt = 1'b1;
  end

  // Fault sequencer
  always_comb
  begin
    state_nxt  = state_r;
    tries_nxt  = tries_r;
    out_en_nxt = out_en_r;
    tmr_start  = 1'b0;
    tmr_stop   = 1'b0;
    if (!cmd_on)
    begin
      // Commanded off: output down, sequence abandoned
      state_nxt  = UFR_S_RUN;
      tries_nxt  = 3'h0;
      out_en_nxt = 1'b0;
      tmr_stop   = 1'b1;
    end
    else if (clr_event && state_r != UFR_S_HOLD)
    begin
      state_nxt  = UFR_S_RUN; // RULE12
      tries_nxt  = 3'h0; // RULE17
      out_en_nxt = 1'b1;
      tmr_stop   = 1'b1; // RULE17
    end
    else
    begin
      case (state_r)
        UFR_S_RUN:
        begin
          out_en_nxt = 1'b1;
          if (uv_raw && out_en_r)
          begin
            case (mode)
              UFR_IGNORE:
                state_nxt = UFR_S_RUN; // RULE2
              UFR_DELAYED:
              begin
                state_nxt = UFR_S_GRACE; // RULE3
                tmr_start = 1'b1; // RULE3
              end
              UFR_SHUTDOWN:
              begin
                out_en_nxt = 1'b0; // RULE4
                tmr_start  = 1'b1; // RULE11
                state_nxt  = (retries == `UFR_RETRY_NONE)
                             ? UFR_S_LATCH : UFR_S_OFFW; // RULE6
              end
              default:
              begin
                out_en_nxt = 1'b0; // RULE5
                state_nxt  = UFR_S_HOLD; // RULE5
              end
            endcase
          end
        end
        UFR_S_GRACE:
        begin
          // Runs on through the delay; a vanished fault ends it
          if (!uv_raw)
          begin
            state_nxt = UFR_S_RUN;
            tmr_stop  = 1'b1;
          end
          else if (tmr_done)
          begin
            out_en_nxt = 1'b0; // RULE3
            tmr_start  = 1'b1; // RULE11
            state_nxt  = (retries == `UFR_RETRY_NONE)
                         ? UFR_S_LATCH : UFR_S_OFFW; // RULE6
          end
        end
        UFR_S_OFFW:
        begin
          // Waits out the spacing, then starts an attempt
          out_en_nxt = 1'b0;
          if (tmr_done)
          begin
            out_en_nxt = 1'b1;
            tmr_start  = 1'b1; // RULE11
            state_nxt  = UFR_S_TRY;
            if (retries != `UFR_RETRY_ENDLESS)
              tries_nxt = tries_r + 3'h1;
          end
        end
        UFR_S_TRY:
        begin
          if (uv_raw)
          begin
            // Timer keeps running so starts stay evenly spaced
            out_en_nxt = 1'b0;
            if (retries == `UFR_RETRY_ENDLESS) // RULE10
              state_nxt = UFR_S_OFFW;
            else if (tries_r < retries) // RULE7 RULE8 RULE9 RULE15
              state_nxt = UFR_S_OFFW;
            else
            begin
              state_nxt = UFR_S_LATCH; // RULE7 RULE8 RULE9 RULE15
              tmr_stop  = 1'b1;
            end
          end
          else if (tmr_done)
          begin
            state_nxt = UFR_S_RUN; // RULE17
            tries_nxt = 3'h0; // RULE17
          end
        end
        UFR_S_LATCH:
        begin
          out_en_nxt = 1'b0; // RULE6
          tmr_stop   = 1'b1;
        end
        UFR_S_HOLD:
        begin
          out_en_nxt = 1'b0;
          if (!uv_raw)
          begin
            out_en_nxt = 1'b1; // RULE5
            state_nxt  = UFR_S_RUN; // RULE5
          end
        end
        default:
        begin
          state_nxt  = UFR_S_RUN;
          out_en_nxt = 1'b0;
        end
      endcase
    end
  end

  // Register file and command path registers
  always_ff @(posedge I_CLOCK)
  begin
    if (I_SYS_RST)
    begin
      action_r  <= `UFR_ACTION_RST;
      limit_r   <= `UFR_LIMIT_RST;
      unit_r    <= `UFR_UNIT_RST;
      op_r      <= `UFR_OP_RST;
      stat_r    <= 1'b0;
      cmd_on_r  <= 1'b0;
      rpin_d_r  <= 1'b0;
      rd_data_r <= 16'h0000;
      rd_vld_r  <= 1'b0;
    end
    else
    begin
      action_r  <= action_nxt;
      limit_r   <= limit_nxt;
      unit_r    <= unit_nxt;
      op_r      <= op_nxt;
      stat_r    <= stat_nxt;
      cmd_on_r  <= cmd_on_nxt;
      rpin_d_r  <= rpin_d_nxt;
      rd_data_r <= rd_data_nxt;
      rd_vld_r  <= rd_vld_nxt;
    end
  end

  // Sequencer registers
  always_ff @(posedge I_CLOCK)
  begin
    if (I_SYS_RST)
    begin
      state_r  <= UFR_S_RUN;
      tries_r  <= 3'h0;
      out_en_r <= 1'b0;
    end
    else
    begin
      state_r  <= state_nxt;
      tries_r  <= tries_nxt;
      out_en_r <= out_en_nxt;
    end
  end

  // Outputs straight from flip-flops, except O_LATCHED decoded from the state register
  assign O_RD_DATA   = rd_data_r;
  assign O_RD_VALID  = rd_vld_r;
  assign O_OUTPUT_EN = out_en_r;
  assign O_UV_FAULT  = stat_r;
  assign O_LATCHED   = (state_r == UFR_S_LATCH);
  assign O_ATTEMPTS  = tries_r;
  assign O_STATE     = state_r;

endmodule

`default_nettype wire

// ===== tb/ufr_properties.sv
`timescale 1ns/100ps
`default_nettype none

module ufr_checker
  import ufr_pkg::*;
#(
  parameter int TBASE_CYC = 125
) (
  input wire logic        I_CLOCK,
  input wire logic        I_SYS_RST,
  input wire logic [15:0] I_VOUT,
  input wire logic        I_CMD_WR,
  input wire logic        I_CMD_RD,
  input wire logic [7:0]  I_CMD_CODE,
  input wire logic [15:0] I_CMD_DATA,
  input wire logic        I_CTRL_PIN,
  input wire logic [15:0] O_RD_DATA,
  input wire logic        O_RD_VALID,
  input wire logic        O_OUTPUT_EN,
  input wire logic        O_UV_FAULT,
  input wire logic        O_LATCHED,
  input wire logic [2:0]  O_ATTEMPTS,
  input wire ufr_state_t  O_STATE
);
  logic [7:0]  act_r, act_nxt;
  logic [15:0] lim_r, lim_nxt;
  wire         low = I_VOUT < lim_r;
  wire         run_on = O_STATE == UFR_S_RUN && O_OUTPUT_EN && I_CTRL_PIN
                        && !I_CMD_WR;

  // Shadow copies of the action byte and the fault limit
  always_comb
  begin
    act_nxt = act_r;
    lim_nxt = lim_r;
    if (I_CMD_WR && I_CMD_CODE == 8'h45)
      act_nxt = I_CMD_DATA[7:0];
    if (I_CMD_WR && I_CMD_CODE == 8'h44)
      lim_nxt = I_CMD_DATA;
  end

  always_ff @(posedge I_CLOCK)
  begin
    act_r <= I_SYS_RST ? 8'h80 : act_nxt;
    lim_r <= I_SYS_RST ? 16'h0000 : lim_nxt;
  end

  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (I_SYS_RST);

  // Clear-all write, then back in run with no attempts and output on
  sequence s_clr;
    I_CMD_WR && I_CMD_CODE == 8'h03;
  endsequence
  sequence s_back;
    O_STATE == UFR_S_RUN && O_ATTEMPTS == 3'h0 ##1 O_OUTPUT_EN;
  endsequence

  property p_rd_act;
    I_CMD_RD && !I_CMD_WR && I_CMD_CODE == 8'h45
      |=> O_RD_VALID && O_RD_DATA == {8'h00, act_r};
  endproperty
  a_rd_act: assert property (p_rd_act)
    else $error("action byte read back wrong");

  property p_ignore;
    run_on && low && act_r[7:6] == 2'h0 |=> O_OUTPUT_EN && O_UV_FAULT;
  endproperty
  a_ignore: assert property (p_ignore)
    else $error("ignore mode interrupted output");

  property p_cut;
    run_on && low && act_r[7:6] == 2'h2 |=> !O_OUTPUT_EN && O_UV_FAULT;
  endproperty
  a_cut: assert property (p_cut)
    else $error("shutdown mode did not cut output");

  property p_hold;
    O_STATE == UFR_S_HOLD && low && I_CTRL_PIN && !I_CMD_WR
      |=> O_STATE == UFR_S_HOLD && !O_OUTPUT_EN;
  endproperty
  a_hold: assert property (p_hold)
    else $error("hold left while fault present");

  property p_latch;
    O_LATCHED |-> !O_OUTPUT_EN && O_STATE == UFR_S_LATCH;
  endproperty
  a_latch: assert property (p_latch)
    else $error("latched state with output on");

  property p_clear;
    s_clr ##0 (O_LATCHED && !low && I_CTRL_PIN) |=> s_back;
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear-all did not restart");

  property p_pin_off;
    !I_CTRL_PIN [*3] |=> !O_OUTPUT_EN;
  endproperty
  a_pin_off: assert property (p_pin_off)
    else $error("control pin low but output on");

  property p_tries;
    act_r[5:3] == 3'h7 ? O_ATTEMPTS == 3'h0 : O_ATTEMPTS <= act_r[5:3];
  endproperty
  a_tries: assert property (p_tries)
    else $error("attempt count beyond setting");
endmodule

bind ufr_top ufr_checker #(.TBASE_CYC(TBASE_CYC)) i_ufr_checker (
  .I_CLOCK(I_CLOCK), .I_SYS_RST(I_SYS_RST), .I_VOUT(I_VOUT),
  .I_CMD_WR(I_CMD_WR), .I_CMD_RD(I_CMD_RD), .I_CMD_CODE(I_CMD_CODE),
  .I_CMD_DATA(I_CMD_DATA), .I_CTRL_PIN(I_CTRL_PIN),
  .O_RD_DATA(O_RD_DATA), .O_RD_VALID(O_RD_VALID),
  .O_OUTPUT_EN(O_OUTPUT_EN), .O_UV_FAULT(O_UV_FAULT),
  .O_LATCHED(O_LATCHED), .O_ATTEMPTS(O_ATTEMPTS), .O_STATE(O_STATE)
);

`default_nettype wire

// ===== tb/ufr_host.sv
`timescale 1ns/100ps
`default_nettype none

module ufr_host (
  input  wire logic        i_clock,
  input  wire logic        i_rd_valid,
  input  wire logic [15:0] i_rd_data,
  output var  logic        o_wr,
  output var  logic        o_rd,
  output var  logic [7:0]  o_code,
  output var  logic [15:0] o_data
);
  // Idle command port at time zero
  initial
  begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_code = 8'h00;
    o_data = 16'h0000;
  end

  // One write; released code and data show their inverse
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(posedge i_clock);
    o_wr <= 1'b1;
    o_code <= c;
    o_data <= d;
    @(posedge i_clock);
    o_wr <= 1'b0;
    o_code <= ~c;
    o_data <= ~d;
  endtask

  // One read; answer taken once the strobe edge has landed
  task automatic rd(input logic [7:0] c, output logic [15:0] d,
                    output logic ok);
    @(posedge i_clock);
    o_rd <= 1'b1;
    o_code <= c;
    @(posedge i_clock);
    o_rd <= 1'b0;
    o_code <= ~c;
    #1;
    ok = i_rd_valid;
    d = i_rd_data;
  endtask
endmodule

`default_nettype wire

// ===== tb/ufr_top_tb.sv
`timescale 1ns/100ps
`default_nettype none

module ufr_top_tb;
  import ufr_pkg::*;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] vout = 16'h0200;
  logic        ctrl = 1'b1;
  logic        rstp = 1'b0;
  logic        wr, rd, rdv, en, uvf, lat;
  logic [7:0]  code;
  logic [15:0] data, rdd;
  logic [2:0]  att;
  ufr_state_t  st;
  int          n_fail = 0;
  int          num_checks = 0;

  // 125 MHz clock
  always #4 clk = ~clk;

  ufr_top #(.TBASE_CYC(2)) i_ufr_top (
    .I_CLOCK(clk), .I_SYS_RST(rst), .I_VOUT(vout), .I_CMD_WR(wr),
    .I_CMD_RD(rd), .I_CMD_CODE(code), .I_CMD_DATA(data),
    .I_CTRL_PIN(ctrl), .I_RESET_PIN(rstp), .O_RD_DATA(rdd),
    .O_RD_VALID(rdv), .O_OUTPUT_EN(en), .O_UV_FAULT(uvf),
    .O_LATCHED(lat), .O_ATTEMPTS(att), .O_STATE(st)
  );

  ufr_host i_ufr_host (
    .i_clock(clk), .i_rd_valid(rdv), .i_rd_data(rdd),
    .o_wr(wr), .o_rd(rd), .o_code(code), .o_data(data)
  );

  task automatic end_of_test();
    if (n_fail == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // Settle just after a rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic w(input logic [7:0] c, input logic [15:0] d);
    i_ufr_host.wr(c, d);
  endtask

  task automatic rdchk(input logic [7:0] c, input logic [15:0] e);
    logic [15:0] d;
    logic        ok;
    i_ufr_host.rd(c, d, ok);
    chk({15'h0, ok}, 16'h0001);
    chk(d, e);
  endtask

  task automatic set_v(input logic [15:0] v);
    @(posedge clk);
    vout <= v;
  endtask

  task automatic drv(input logic c, input logic p);
    @(posedge clk);
    ctrl <= c;
    rstp <= p;
  endtask

  // Bounded wait for the output enable to reach a level
  task automatic wait_en(input logic v, input int lim);
    int i;
    for (i = 0; i < lim; i++)
    begin
      tick(1);
      if (en === v)
        break;
    end
    if (en !== v)
    begin
      n_fail++;
      $display("unexpected at %0t: enable wait ran out", $time);
      end_of_test();
    end
  endtask

  // Count restarts and the spacing of the last two, until latched
  task automatic watch(input int cyc, output int r, output int d);
    int   i;
    int   t;
    logic p;
    r = 0;
    d = 0;
    t = 0;
    p = en;
    for (i = 0; i < cyc && lat !== 1'b1; i++)
    begin
      tick(1);
      if (en === 1'b1 && p === 1'b0)
      begin
        d = i - t;
        t = i;
        r++;
      end
      p = en;
    end
  endtask

  // Pin pulse: reset pin when p is high, control pin low otherwise
  task automatic pulse(input logic p);
    drv(p, p);
    tick(5);
    drv(1'b1, 1'b0);
  endtask

  task automatic onoff();
    w(8'h01, 16'h0000);
    w(8'h01, 16'h0080);
  endtask

  task automatic t_regs();
    rdchk(8'h45, 16'h0080);
    w(8'h45, 16'h00A5);
    rdchk(8'h45, 16'h00A5);
    rdchk(8'h55, 16'h0000);
  endtask

  // Limit boundary with the fault ignored
  task automatic t_mode00();
    w(8'h44, 16'h0100);
    w(8'h45, 16'h0000);
    set_v(16'h0100);
    tick(5);
    chk({15'h0, uvf}, 16'h0000);
    set_v(16'h00FF);
    tick(5);
    chk({14'h0, uvf, en}, 16'h0003);
    rdchk(8'h7A, 16'h0010);
    set_v(16'h0200);
    w(8'h7A, 16'h0010);
    rdchk(8'h7A, 16'h0000);
  endtask

  // Retry counts 0 to 6 with a fault that never goes away
  task automatic t_retry();
    int n, r, d;
    for (n = 0; n < 7; n++)
    begin
      w(8'h45, {8'h00, 2'b10, n[2:0], 3'b000});
      set_v(16'h0050);
      watch(300, r, d);
      chk(16'(r), 16'(n));
      chk({13'h0, att}, 16'(n));
      chk({14'h0, lat, en}, 16'h0002);
      set_v(16'h0200);
      case (n % 5)
        0: w(8'h03, 16'h0000);
        1: w(8'h7A, 16'h0010);
        2: pulse(1'b1);
        3: onoff();
        default: pulse(1'b0);
      endcase
      wait_en(1'b1, 20);
      chk({13'h0, att}, 16'h0000);
    end
  endtask

  // Endless retries: start-to-start spacing for multipliers 0 to 2
  task automatic t_space();
    int m, r, d;
    w(8'hD2, 16'h0003);
    for (m = 0; m < 3; m++)
    begin
      w(8'h45, {8'h00, 5'b10111, m[2:0]});
      set_v(16'h0050);
      watch(100, r, d);
      chk(16'(d), 16'(6 << m));
      chk({12'h0, lat, att}, 16'h0000);
      w(8'h01, 16'h0000);
      tick(2);
      chk({15'h0, en}, 16'h0000);
      set_v(16'h0200);
      w(8'h01, 16'h0080);
      wait_en(1'b1, 10);
    end
  endtask

  // Run on through the delay, then latch with no retry
  task automatic t_mode01();
    w(8'h45, 16'h0042);
    set_v(16'h0050);
    tick(12);
    chk({15'h0, en}, 16'h0001);
    wait_en(1'b0, 30);
    tick(1);
    chk({15'h0, lat}, 16'h0001);
    set_v(16'h0200);
    w(8'h03, 16'h0000);
    wait_en(1'b1, 10);
  endtask

  // One restart that succeeds: back to run with the count cleared
  task automatic t_recover();
    w(8'h45, 16'h0098);
    set_v(16'h0050);
    wait_en(1'b0, 5);
    set_v(16'h0200);
    wait_en(1'b1, 20);
    chk({13'h0, att}, 16'h0001);
    tick(8);
    chk({9'h0, st, att, en}, 16'h0001);
  endtask

  task automatic t_mode11();
    w(8'h45, 16'h00C0);
    set_v(16'h0050);
    wait_en(1'b0, 5);
    chk({13'h0, st}, 16'h0007);
    set_v(16'h0200);
    wait_en(1'b1, 10);
  endtask

  // Main sequence
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    wait_en(1'b1, 10);
    t_regs();
    t_mode00();
    t_retry();
    t_space();
    t_mode01();
    t_recover();
    t_mode11();
    end_of_test();
  end
endmodule

`default_nettype wire
